// >>> src/fcs_pkg.sv
package fcs_pkg;
	// register index as printed; byte address is four times it
	localparam logic [11:0] FCS_CTRL_IDX = 12'h016;
	localparam logic [11:0] FCS_CTRL_ADDR = 12'h058;
	localparam int FCS_ADDR_W = 12;
	localparam int FCS_DATA_W = 32;
	localparam int FCS_REG_W = 16;

	// field positions
	localparam int FCS_TQ_BIT = 10;
	localparam int FCS_SDF_BIT = 9;
	localparam int FCS_SDA_BIT = 8;
	localparam int FCS_DTO_BIT = 7;
	localparam int FCS_F100_BIT = 5;
	localparam int FCS_NRZ_BIT = 2;

	// writable bits; reserved ones store nothing and read zero
	localparam logic [15:0] FCS_WR_MASK = 16'h07A4;
	localparam logic [15:0] FCS_RESET_VAL = 16'h0100;

	// descrambler lock timeouts
	localparam int FCS_CLK_MHZ = 250;
	localparam int FCS_DTO_LONG_US = 2000;
	localparam int FCS_DTO_SHORT_US = 722;
	localparam int FCS_DTO_LONG_CYC = FCS_DTO_LONG_US * FCS_CLK_MHZ;
	localparam int FCS_DTO_SHORT_CYC = FCS_DTO_SHORT_US * FCS_CLK_MHZ;
	localparam int FCS_DTO_W = 20;
endpackage

// >>> src/fcs_ctrl_reg.sv
`timescale 1ns/1ps
// Behaviour
// - control register sits at management register index 0x16
// - bits 15 to 13 read zero, writes to them dropped
// - bit 10, reset 0, enables true quiet transmit
// - bit 9, reset 0, forces signal detect in the attachment sublayer
// - bit 8, reset 1, selects enhanced signal detect, else reduced
// - bit 7, reset 0, descrambler timeout 2ms when set, else 722us
// - bit 5, reset 0, forces good 100 Mb/s link
// - bit 2, reset 0, bypasses line encode and decode stage
module fcs_ctrl_reg #(
	parameter int DTO_LONG_CYC = fcs_pkg::FCS_DTO_LONG_CYC,
	parameter int DTO_SHORT_CYC = fcs_pkg::FCS_DTO_SHORT_CYC
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fcs_pkg::FCS_ADDR_W-1:0] paddr,
	input wire logic [fcs_pkg::FCS_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [fcs_pkg::FCS_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// controls to the coding sublayer
	output logic true_quiet_transmit_enable,
	output logic signal_detect_force,
	output logic signal_detect_algo_select,
	output logic descrambler_timeout_select,
	output logic force_100_good_link,
	output logic line_code_bypass,
	output logic [fcs_pkg::FCS_DTO_W-1:0] descrambler_timeout_cycles
);
	import fcs_pkg::*;

	localparam logic [FCS_DTO_W-1:0] DTO_LONG = DTO_LONG_CYC[FCS_DTO_W-1:0];
	localparam logic [FCS_DTO_W-1:0] DTO_SHORT =
		DTO_SHORT_CYC[FCS_DTO_W-1:0];

	logic [FCS_REG_W-1:0] ctrl_r;
	logic [FCS_REG_W-1:0] ctrl_nxt;
	logic [FCS_DATA_W-1:0] prdata_r;
	logic [FCS_DATA_W-1:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic [FCS_DTO_W-1:0] dto_r;
	logic [FCS_DTO_W-1:0] dto_nxt;
	logic hit;
	logic setup;
	logic wr_go;
	logic [FCS_REG_W-1:0] wdata;

	assign hit = (paddr == FCS_CTRL_ADDR);
	assign setup = psel && !penable;
	assign wr_go = psel && penable && pready_r && pwrite && hit;

	// byte lanes 0 and 1 carry the 16-bit register
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_lane
			assign wdata[gi*8 +: 8] = pstrb[gi] ?
				pwdata[gi*8 +: 8] : ctrl_r[gi*8 +: 8];
		end
	endgenerate

	// register contents
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_go) begin
			// reserved bits dropped on write
			ctrl_nxt = wdata & FCS_WR_MASK;
		end
	end

	// timeout count follows the select bit, one flop deep
	always_comb begin
		dto_nxt = ctrl_nxt[FCS_DTO_BIT] ? DTO_LONG : DTO_SHORT;
	end

	// apb answer: registered one cycle after setup, so pready is a flop
	always_comb begin
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (setup) begin
			pready_nxt = 1'b1;
			pslverr_nxt = !hit;
			prdata_nxt = '0;
			if (!pwrite && hit) begin
				prdata_nxt[FCS_REG_W-1:0] = ctrl_r & FCS_WR_MASK;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= FCS_RESET_VAL;
			dto_r <= DTO_SHORT;
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			ctrl_r <= ctrl_nxt;
			dto_r <= dto_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign true_quiet_transmit_enable = ctrl_r[FCS_TQ_BIT];
	assign signal_detect_force = ctrl_r[FCS_SDF_BIT];
	assign signal_detect_algo_select = ctrl_r[FCS_SDA_BIT];
	assign descrambler_timeout_select = ctrl_r[FCS_DTO_BIT];
	assign force_100_good_link = ctrl_r[FCS_F100_BIT];
	assign line_code_bypass = ctrl_r[FCS_NRZ_BIT];
	assign descrambler_timeout_cycles = dto_r;

	// checks
	logic wr_full;
	assign wr_full = wr_go && ce && pstrb[1] && pstrb[0];

	property p_offset_write;
		@(posedge mclk) disable iff (!reset_n)
		(psel && penable && pready && pwrite && ce && paddr != FCS_CTRL_ADDR)
		|=> $stable(ctrl_r);
	endproperty
	a_offset_write: assert property (p_offset_write)
		else $error("write off the register index changed it");

	property p_resv_read;
		@(posedge mclk) disable iff (!reset_n)
		pready |-> prdata[FCS_DATA_W-1:13] == '0 && !(pslverr && prdata != '0);
	endproperty
	a_resv_read: assert property (p_resv_read)
		else $error("reserved bits read nonzero");

	property p_tq;
		@(posedge mclk) disable iff (!reset_n)
		wr_full |=> true_quiet_transmit_enable == $past(pwdata[FCS_TQ_BIT]);
	endproperty
	a_tq: assert property (p_tq)
		else $error("true quiet enable not taken from write");

	property p_sdf;
		@(posedge mclk) disable iff (!reset_n)
		(wr_full && pwdata[FCS_SDF_BIT]) ##1 (!wr_go) |-> signal_detect_force;
	endproperty
	a_sdf: assert property (p_sdf)
		else $error("signal detect force lost");

	property p_sda_reset;
		@(posedge mclk)
		$rose(reset_n) |-> signal_detect_algo_select && !signal_detect_force
			&& !true_quiet_transmit_enable;
	endproperty
	a_sda_reset: assert property (p_sda_reset)
		else $error("wrong reset value of signal detect algorithm");

	property p_dto;
		@(posedge mclk) disable iff (!reset_n)
		descrambler_timeout_cycles ==
			(descrambler_timeout_select ? DTO_LONG : DTO_SHORT);
	endproperty
	a_dto: assert property (p_dto)
		else $error("descrambler timeout count disagrees with select");

	property p_f100;
		@(posedge mclk) disable iff (!reset_n)
		wr_full |=> force_100_good_link == $past(pwdata[FCS_F100_BIT])
			&& ctrl_r[12:11] == 2'b00;
	endproperty
	a_f100: assert property (p_f100)
		else $error("good link force not taken from write");

	property p_nrz;
		@(posedge mclk) disable iff (!reset_n)
		(psel && penable && pready && !pwrite && !pslverr)
		|-> prdata[FCS_NRZ_BIT] == line_code_bypass;
	endproperty
	a_nrz: assert property (p_nrz)
		else $error("line code bypass readback mismatch");

	property p_ready_pulse;
		@(posedge mclk) disable iff (!reset_n)
		(setup && ce) |=> pready ##1 (!pready || !ce);
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready not a single access cycle");

	property p_err_with_ready;
		@(posedge mclk) disable iff (!reset_n)
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready)
		else $error("error flag raised outside an access cycle");

	property p_err_addr;
		@(posedge mclk) disable iff (!reset_n)
		(setup && ce) |=> pslverr == !$past(hit);
	endproperty
	a_err_addr: assert property (p_err_addr)
		else $error("error flag disagrees with the register index");

	property p_err_zero;
		@(posedge mclk) disable iff (!reset_n)
		(setup && ce && !hit) |=> prdata == '0;
	endproperty
	a_err_zero: assert property (p_err_zero)
		else $error("unmapped access returned data");

	property p_rd_data;
		@(posedge mclk) disable iff (!reset_n)
		(setup && ce && !pwrite && hit) |=>
			prdata[FCS_REG_W-1:0] == $past(ctrl_r)
			&& prdata[FCS_DATA_W-1:FCS_REG_W] == '0;
	endproperty
	a_rd_data: assert property (p_rd_data)
		else $error("read data is not the register contents");

	// reserved bits must never be stored, whatever was written
	property p_resv_store;
		@(posedge mclk) disable iff (!reset_n)
		(ctrl_r & ~FCS_WR_MASK) == '0;
	endproperty
	a_resv_store: assert property (p_resv_store)
		else $error("reserved bit stored");

	property p_lane_keep;
		@(posedge mclk) disable iff (!reset_n)
		(wr_go && ce && !pstrb[1]) |=> $stable(ctrl_r[FCS_REG_W-1:8]);
	endproperty
	a_lane_keep: assert property (p_lane_keep)
		else $error("upper lane changed without its strobe");

	property p_tq_hold;
		@(posedge mclk) disable iff (!reset_n)
		!wr_go |=> $stable(true_quiet_transmit_enable);
	endproperty
	a_tq_hold: assert property (p_tq_hold)
		else $error("true quiet enable changed without a write");

	property p_sdf_take;
		@(posedge mclk) disable iff (!reset_n)
		wr_full |=> signal_detect_force == $past(pwdata[FCS_SDF_BIT]);
	endproperty
	a_sdf_take: assert property (p_sdf_take)
		else $error("signal detect force not taken from write");

	property p_sda_take;
		@(posedge mclk) disable iff (!reset_n)
		wr_full |=> signal_detect_algo_select == $past(pwdata[FCS_SDA_BIT]);
	endproperty
	a_sda_take: assert property (p_sda_take)
		else $error("signal detect algorithm not taken from write");

	property p_dto_take;
		@(posedge mclk) disable iff (!reset_n)
		wr_full |=> descrambler_timeout_select == $past(pwdata[FCS_DTO_BIT]);
	endproperty
	a_dto_take: assert property (p_dto_take)
		else $error("descrambler timeout select not taken from write");

	property p_f100_hold;
		@(posedge mclk) disable iff (!reset_n)
		!wr_go |=> $stable(force_100_good_link);
	endproperty
	a_f100_hold: assert property (p_f100_hold)
		else $error("good link force changed without a write");

	property p_nrz_take;
		@(posedge mclk) disable iff (!reset_n)
		wr_full |=> line_code_bypass == $past(pwdata[FCS_NRZ_BIT]);
	endproperty
	a_nrz_take: assert property (p_nrz_take)
		else $error("line code bypass not taken from write");

	property p_nrz_hold;
		@(posedge mclk) disable iff (!reset_n)
		!wr_go |=> $stable(line_code_bypass);
	endproperty
	a_nrz_hold: assert property (p_nrz_hold)
		else $error("line code bypass changed without a write");

	c_write: cover property (@(posedge mclk) disable iff (!reset_n) wr_full);
	c_read: cover property (@(posedge mclk) disable iff (!reset_n)
		psel && penable && pready && !pwrite && !pslverr);
	c_err: cover property (@(posedge mclk) disable iff (!reset_n)
		pready && pslverr);
	c_long: cover property (@(posedge mclk) disable iff (!reset_n)
		$rose(descrambler_timeout_select));
	c_frozen: cover property (@(posedge mclk) disable iff (!reset_n)
		setup && !ce);
endmodule

// >>> bench/fcs_testbench.sv
`timescale 1ns/1ps
module testbench;
	import fcs_pkg::*;
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic ce;
	logic tq, sdf, sda, dto, f100, nrz;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [19:0] dto_cyc;
	int miscompares, num_checks;
	localparam logic [11:0] A = 12'h058;
	// short timeouts keep the count outputs easy to predict
	fcs_ctrl_reg #(.DTO_LONG_CYC(20), .DTO_SHORT_CYC(7)) DUT(.mclk(mclk),
		.reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.true_quiet_transmit_enable(tq), .signal_detect_force(sdf),
		.signal_detect_algo_select(sda), .descrambler_timeout_select(dto),
		.force_100_good_link(f100), .line_code_bypass(nrz),
		.descrambler_timeout_cycles(dto_cyc));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic wrap_up();
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, then an idle cycle so strobes never clash
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// clock enable low: the setup is not taken until it rises
	task automatic frozen();
		ce <= 1'b0;
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= A;
		pwdata <= 32'h0000_0080;
		pstrb <= 4'hF;
		repeat (3) @(posedge mclk);
		chk({31'h0, pready}, 32'h0);
		ce <= 1'b1;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
		chk_reg(16'h0080);
	endtask
	task automatic chk_reg(input logic [15:0] v);
		xfer(1'b0, A, 32'h0, 4'h0);
		chk(rd, {16'h0, v});
		chk({31'h0, err}, 32'h0);
		chk({26'h0, tq, sdf, sda, dto, f100, nrz},
			{26'h0, v[10], v[9], v[8], v[7], v[5], v[2]});
		chk({12'h0, dto_cyc}, v[7] ? 32'd20 : 32'd7);
	endtask
	task automatic wr_chk(input logic [15:0] v, input logic [15:0] e);
		xfer(1'b1, A, {16'hFFFF, v}, 4'hF);
		chk_reg(e);
	endtask
	task automatic unmapped();
		xfer(1'b1, 12'h054, 32'hFFFF_FFFF, 4'hF);
		chk({31'h0, err}, 32'h1);
		xfer(1'b0, 12'h054, 32'h0, 4'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		chk_reg(16'h0424);
	endtask
	initial begin
		repeat (2000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		chk_reg(16'h0100);
		wr_chk(16'hE7A4, 16'h07A4);
		// low lane only: upper byte keeps its bits
		xfer(1'b1, A, 32'h0, 4'h1);
		chk_reg(16'h0700);
		wr_chk(16'hE000, 16'h0000);
		wr_chk(16'h0424, 16'h0424);
		unmapped();
		frozen();
		reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		chk_reg(16'h0100);
		wrap_up();
	end
endmodule
